// >>> design/error_count.sv
// Error queue occupancy counter.
`timescale 1ns/1ps
`default_nettype none
module error_count import status_pkg::*; #(
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_sync_b,
	// Queue events.
	input  wire logic push,
	input  wire logic pop,
	// Status.
	output logic      not_empty
);
	localparam int W = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [W-1:0] cnt;
	} cnt_state_type;

	cnt_state_type s_q;
	cnt_state_type s_d;

	if (DEPTH < 1) begin : g_bad_depth
		$error("DEPTH must be at least one.");
	end

	// Pop before push so a full queue still takes a new entry when one leaves.
	always_comb begin
		s_d = s_q;
		if (pop && s_q.cnt != '0) begin // see RULE8
			s_d.cnt = s_q.cnt - W'(1);
		end
		if (push && s_d.cnt != W'(DEPTH)) begin
			s_d.cnt = s_d.cnt + W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign not_empty = (s_q.cnt != '0);

endmodule // error_count
`default_nettype wire

// >>> design/status_event_summary.sv
// Standard event register and status summary byte.
`timescale 1ns/1ps
`default_nettype none
module status_event_summary import status_pkg::*; #(
	parameter int ERR_DEPTH = 16
) (
	// Clock and reset.
	input  wire logic            clk,
	input  wire logic            rst_b,
	// Event strobes.
	input  wire event_in_type    evt,
	input  wire logic            err_push,
	// Host commands.
	input  wire host_cmd_type    cmd,
	// Summary sources.
	input  wire summary_src_type src,
	// Register views.
	output logic [7:0]           std_event_flags,
	output logic [7:0]           service_summary_byte,
	output logic                 service_request
);

	////////////////////////////////////////////////////////////////////////////
	// Reset release.

	logic [1:0] rst_sync_q;
	logic       rst_sync_b;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_q <= '0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_sync_b = rst_sync_q[1];

	////////////////////////////////////////////////////////////////////////////
	// Error queue.

	logic err_not_empty;

	error_count #(
		.DEPTH (ERR_DEPTH)
	) u_err (
		.clk        (clk),
		.rst_sync_b (rst_sync_b),
		.push       (err_push),
		.pop        (cmd.err_pop),
		.not_empty  (err_not_empty)
	);

	////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic [7:0] ev;
		logic [7:0] ese;
		logic [7:0] sre;
		logic [7:0] stb;
		logic       srq;
	} state_type;

	state_type s_q;
	state_type s_d;
	logic [7:0] ev_set;
	logic [7:0] sum;

	function automatic logic any_masked(input logic [15:0] v, input logic [15:0] m);
		return |(v & m);
	endfunction

	always_comb begin
		ev_set = '0;
		ev_set[EVT_OPC]    = evt.opc_done; // see RULE1
		ev_set[EVT_QUERY]  = evt.out_empty_read | evt.query_overrun
			| evt.buffers_full; // see RULE2
		ev_set[EVT_DEVICE] = evt.device_err; // see RULE3
		ev_set[EVT_EXEC]   = evt.exec_err; // see RULE4
		ev_set[EVT_CMD]    = evt.cmd_err; // see RULE5
		s_d = s_q;
		// A read clears the flags, but an event in the same cycle survives.
		if (cmd.event_read || cmd.event_clear) begin
			s_d.ev = '0; // see RULE15, RULE6
		end
		s_d.ev = (s_d.ev | ev_set) & EVT_USED_MASK; // see RULE14
		if (cmd.ese_write) begin
			s_d.ese = cmd.mask_data & EVT_USED_MASK;
		end
		if (cmd.sre_write) begin
			s_d.sre = cmd.mask_data & SUM_SRE_MASK;
		end
		sum = '0;
		sum[SUM_ALARM] = any_masked(src.alarm, src.alarm_mask); // see RULE7
		sum[SUM_ERRQ]  = err_not_empty; // see RULE8
		sum[SUM_QUES]  = any_masked(src.ques, src.ques_mask); // see RULE9
		sum[SUM_MAV]   = src.out_avail; // see RULE10
		sum[SUM_EVENT] = |(s_q.ev & s_q.ese); // see RULE11
		sum[SUM_OPER]  = any_masked(src.oper, src.oper_mask); // see RULE13
		sum[SUM_RQS]   = |(sum & s_q.sre); // see RULE12
		s_d.stb = sum; // see RULE16
		s_d.srq = sum[SUM_RQS];
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			s_q <= '{ev: EVT_RESET, default: '0}; // see RULE6
		end else begin
			s_q <= s_d;
		end
	end

	assign std_event_flags      = s_q.ev;
	assign service_summary_byte = s_q.stb;
	assign service_request      = s_q.srq;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_b);

	a_opc_sets: assert property (evt.opc_done |=> std_event_flags[EVT_OPC]) // see RULE1
		else $error("Completion flag not set.");

	a_opc_keep: assert property (std_event_flags[EVT_OPC] // see RULE1
		&& !cmd.event_read && !cmd.event_clear |=> std_event_flags[EVT_OPC])
		else $error("Completion flag lost without a read.");

	a_query_sets: assert property ((evt.query_overrun || evt.buffers_full) // see RULE2
		|=> std_event_flags[EVT_QUERY])
		else $error("Query error flag not set.");

	a_empty_read: assert property (evt.out_empty_read // see RULE2
		|=> std_event_flags[EVT_QUERY])
		else $error("Empty read flag not set.");

	a_device_sets: assert property (evt.device_err |=> std_event_flags[EVT_DEVICE]) // see RULE3
		else $error("Device error flag not set.");

	a_exec_sets: assert property (evt.exec_err |=> std_event_flags[EVT_EXEC]) // see RULE4
		else $error("Execution error flag not set.");

	a_cmd_sets: assert property (evt.cmd_err |=> std_event_flags[EVT_CMD]) // see RULE5
		else $error("Command error flag not set.");

	a_power_hold: assert property (std_event_flags[EVT_POWER] && !cmd.event_read // see RULE6
		&& !cmd.event_clear |=> std_event_flags[EVT_POWER])
		else $error("Power flag lost without a read.");

	a_power_once: assert property (!std_event_flags[EVT_POWER] // see RULE6
		|=> !std_event_flags[EVT_POWER])
		else $error("Power flag set without a power cycle.");

	a_alarm_sum: assert property (any_masked(src.alarm, src.alarm_mask) // see RULE7
		|=> service_summary_byte[SUM_ALARM])
		else $error("Alarm summary wrong.");

	a_alarm_low: assert property (!any_masked(src.alarm, src.alarm_mask) // see RULE7
		|=> !service_summary_byte[SUM_ALARM])
		else $error("Alarm summary stuck high.");

	a_errq_sum: assert property (err_push && !cmd.err_pop // see RULE8
		|=> ##1 service_summary_byte[SUM_ERRQ])
		else $error("Error queue summary wrong.");

	a_errq_empty: assert property (!err_not_empty // see RULE8
		|=> !service_summary_byte[SUM_ERRQ])
		else $error("Error queue summary stuck high.");

	a_ques_sum: assert property (service_summary_byte[SUM_QUES] // see RULE9
		== $past(any_masked(src.ques, src.ques_mask)))
		else $error("Questionable summary wrong.");

	a_mav_sum: assert property (service_summary_byte[SUM_MAV] == $past(src.out_avail)) // see RULE10
		else $error("Message summary wrong.");

	a_event_sum: assert property (|(std_event_flags & s_q.ese) // see RULE11
		|=> service_summary_byte[SUM_EVENT])
		else $error("Event summary wrong.");

	a_event_drop: assert property (!(|(std_event_flags & s_q.ese)) // see RULE11
		|=> !service_summary_byte[SUM_EVENT])
		else $error("Event summary stuck high.");

	a_ese_load: assert property (cmd.ese_write // see RULE11
		|=> s_q.ese == $past(cmd.mask_data & EVT_USED_MASK))
		else $error("Event mask not loaded.");

	a_rqs_link: assert property (service_request == service_summary_byte[SUM_RQS]) // see RULE12
		else $error("Service request mismatch.");

	a_rqs_source: assert property (service_summary_byte[SUM_RQS] // see RULE12
		== |(service_summary_byte & SUM_SRE_MASK & $past(s_q.sre)))
		else $error("Service request source wrong.");

	a_sre_load: assert property (cmd.sre_write // see RULE12
		|=> s_q.sre == $past(cmd.mask_data & SUM_SRE_MASK))
		else $error("Service mask not loaded.");

	a_oper_sum: assert property (service_summary_byte[SUM_OPER] // see RULE13
		== $past(any_masked(src.oper, src.oper_mask)))
		else $error("Operation summary wrong.");

	a_reserved_zero: assert property (!std_event_flags[1] && !std_event_flags[6] // see RULE14
		&& !service_summary_byte[0])
		else $error("Reserved bit set.");

	a_mask_reserved: assert property (!s_q.ese[1] && !s_q.ese[6] // see RULE14
		&& !s_q.sre[SUM_RQS])
		else $error("Reserved mask bit set.");

	a_read_clears: assert property (cmd.event_read && ev_set == '0 // see RULE15
		|=> std_event_flags == '0)
		else $error("Read did not clear.");

	a_clear_clears: assert property (cmd.event_clear && ev_set == '0 // see RULE15
		|=> std_event_flags == '0)
		else $error("Clear did not clear.");

	a_flags_hold: assert property (ev_set == '0 && !cmd.event_read // see RULE15
		&& !cmd.event_clear |=> std_event_flags == $past(std_event_flags))
		else $error("Flags changed without cause.");

	a_sum_fresh: assert property (service_summary_byte == $past(sum)) // see RULE16
		else $error("Summary not current.");

	c_opc: cover property (evt.opc_done ##1 cmd.event_read);
	c_rqs: cover property (!service_request ##1 service_request);
	c_errq: cover property (err_push ##2 cmd.err_pop);
	c_power_read: cover property (std_event_flags[EVT_POWER] ##1 !std_event_flags[EVT_POWER]);
	c_set_wins: cover property (cmd.event_read && evt.cmd_err);

endmodule // status_event_summary
`default_nettype wire

// >>> design/status_pkg.sv
// Constants, types and operation summary for the status event summary block.
// Operation
// RULE1 - Standard event bit 0 is set once all commands up to and including the completion marker have run.
// RULE2 - Standard event bit 2 is set on an empty output read, an unread query overrun, or both buffers full.
// RULE3 - Standard event bit 3 is set on any device-range error or positive error code.
// RULE4 - Standard event bit 4 is set on any execution-range error.
// RULE5 - Standard event bit 5 is set on any command syntax error.
// RULE6 - Standard event bit 7 is set after power-up and holds until the register is read or cleared.
// RULE7 - Summary bit 1 is high while any alarm bit enabled by the alarm mask is set.
// RULE8 - Summary bit 2 is high while the error queue is not empty, and an error query pops one entry.
// RULE9 - Summary bit 3 is high while any questionable bit enabled by its mask is set.
// RULE10 - Summary bit 4 is high while the output buffer holds unread data.
// RULE11 - Summary bit 5 is high while any standard event bit enabled by its mask is set.
// RULE12 - Summary bit 6 is high when any summary bit enabled by the service mask is set, raising a service request.
// RULE13 - Summary bit 7 is high while any operation bit enabled by its mask is set.
// RULE14 - Summary bit 0 and standard event bits 1 and 6 are reserved.
// RULE15 - Reading the standard event register clears it, and reserved bits read as zero.
// RULE16 - Every summary bit is recomputed each cycle from current contents and masks.
package status_pkg;

	localparam int EVT_OPC      = 0;
	localparam int EVT_QUERY    = 2;
	localparam int EVT_DEVICE   = 3;
	localparam int EVT_EXEC     = 4;
	localparam int EVT_CMD      = 5;
	localparam int EVT_POWER    = 7;
	localparam int SUM_ALARM    = 1;
	localparam int SUM_ERRQ     = 2;
	localparam int SUM_QUES     = 3;
	localparam int SUM_MAV      = 4;
	localparam int SUM_EVENT    = 5;
	localparam int SUM_RQS      = 6;
	localparam int SUM_OPER     = 7;
	localparam logic [7:0] EVT_USED_MASK = 8'hBD;
	localparam logic [7:0] SUM_SRE_MASK  = 8'hBF;
	localparam logic [7:0] EVT_RESET     = 8'h80;
	localparam int SYNC_RESET_MASK       = 0;

	// Completion and error class strobes raised by the command parser.
	typedef struct packed {
		logic opc_done;
		logic out_empty_read;
		logic query_overrun;
		logic buffers_full;
		logic device_err;
		logic exec_err;
		logic cmd_err;
	} event_in_type;

	// Host accesses and mask writes.
	typedef struct packed {
		logic       event_read;
		logic       event_clear;
		logic       err_pop;
		logic       ese_write;
		logic       sre_write;
		logic [7:0] mask_data;
	} host_cmd_type;

	// Summary sources from the wider status system.
	typedef struct packed {
		logic [15:0] alarm;
		logic [15:0] alarm_mask;
		logic [15:0] ques;
		logic [15:0] ques_mask;
		logic [15:0] oper;
		logic [15:0] oper_mask;
		logic        out_avail;
	} summary_src_type;

endpackage

// >>> test/host_model.sv
// Remote host model issuing status commands to the device.
`timescale 1ns/1ps
`default_nettype none
module host_model import status_pkg::*; (
	// Clock.
	input  wire logic        clk,
	// Commands to the device.
	output var host_cmd_type cmd
);
	initial cmd = '0;

	// Holds one command for one cycle: 0 read, 1 clear, 2 pop, 3 event mask, 4 service mask.
	// An idle cycle follows so that back-to-back calls never drive cmd twice in one step.
	task automatic issue(input int ty, input logic [7:0] d);
		host_cmd_type c;
		c = '0;
		c.mask_data = d;
		case (ty)
			0: c.event_read = 1'b1;
			1: c.event_clear = 1'b1;
			2: c.err_pop = 1'b1;
			3: c.ese_write = 1'b1;
			default: c.sre_write = 1'b1;
		endcase
		cmd = c;
		@(negedge clk);
		cmd = '0;
		@(negedge clk);
	endtask
endmodule // host_model
`default_nettype wire

// >>> test/status_event_summary_test.sv
// Self-checking testbench for the status event summary block.
`timescale 1ns/1ps
`default_nettype none
module status_event_summary_test import status_pkg::*;;
	logic            clk      = 1'b0;
	logic            rst_b    = 1'b0;
	logic            err_push = 1'b0;
	logic            look     = 1'b0;
	event_in_type    evt      = '0;
	summary_src_type src      = '0;
	host_cmd_type    cmd;
	logic [7:0]      flags;
	logic [7:0]      sum;
	logic            srq;
	logic [9:0]      nq[$];
	logic [9:0]      nt;
	int              bad_count = 0;
	int              n_tests   = 0;
	localparam logic [7:0] EXP [7] = '{8'h01, 8'h04, 8'h04, 8'h04, 8'h08, 8'h10, 8'h20};

	always #5 clk = ~clk;

	status_event_summary #(.ERR_DEPTH(2)) i_dut (.clk(clk), .rst_b(rst_b), .evt(evt),
		.err_push(err_push), .cmd(cmd), .src(src), .std_event_flags(flags),
		.service_summary_byte(sum), .service_request(srq));
	host_model i_host (.clk(clk), .cmd(cmd));

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp_flags(input logic [7:0] e, input logic [7:0] s);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED std_event_flags expected %h seen %h", e, s);
		end
	endtask
	task automatic cmp_sum(input logic [8:0] e, input logic [8:0] s);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED service request and summary expected %h seen %h", e, s);
		end
	endtask

	// Takes the oldest note whenever a result is shown.
	always @(posedge clk) begin
		if (look || cmd.event_read) begin
			nt = nq.pop_front();
			if (nt[9]) cmp_sum(nt[8:0], {srq, sum});
			else cmp_flags(nt[7:0], flags);
		end
	end

	task automatic rd(input logic [7:0] e);
		nq.push_back({2'b00, e});
		i_host.issue(0, 8'h00);
	endtask
	task automatic sm(input logic [8:0] e);
		repeat (2) @(negedge clk);
		nq.push_back({1'b1, e});
		look = 1'b1;
		@(negedge clk);
		look = 1'b0;
	endtask
	task automatic ev(input int i);
		evt = event_in_type'(7'h40 >> i);
		@(negedge clk);
		evt = '0;
	endtask
	task automatic push(input int n);
		err_push = 1'b1;
		repeat (n) @(negedge clk);
		err_push = 1'b0;
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [8:0] e;
		logic [7:0] s;
		void'($urandom(32'h93A45EF3));
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		rd(8'h80);
		rd(8'h00);
		$display("power-on test done");
		for (int i = 0; i < 7; i++) begin
			ev(i);
			rd(EXP[i]);
		end
		evt.cmd_err = 1'b1;
		rd(8'h00);
		evt = '0;
		rd(8'h20);
		ev(0);
		i_host.issue(1, 8'h00);
		rd(8'h00);
		$display("event test done");
		i_host.issue(3, 8'hFF);
		i_host.issue(4, 8'h20);
		ev(6);
		sm(9'h160);
		rd(8'h20);
		sm(9'h000);
		$display("event summary test done");
		i_host.issue(4, 8'h04);
		push(3);
		i_host.issue(2, 8'h00);
		sm(9'h144);
		i_host.issue(2, 8'h00);
		sm(9'h000);
		i_host.issue(2, 8'h00);
		push(1);
		sm(9'h144);
		i_host.issue(2, 8'h00);
		$display("error queue test done");
		for (int i = 0; i < 16; i++) begin
			s = 8'($urandom());
			i_host.issue(4, s);
			s = s & SUM_SRE_MASK;
			src = {$urandom(), $urandom(), $urandom(), i[0]};
			if (i[1]) src.ques = '0;
			if (i[2]) src.oper_mask = '0;
			if (i[3]) src.alarm = '0;
			e = {1'b0, |(src.oper & src.oper_mask), 2'b00, src.out_avail,
				|(src.ques & src.ques_mask), 1'b0, |(src.alarm & src.alarm_mask), 1'b0};
			e[6] = |(e[7:0] & s);
			e[8] = e[6];
			sm(e);
		end
		$display("random summary test done");
		end_sim();
	end

	initial begin
		#200000;
		bad_count++;
		end_sim();
	end
endmodule // status_event_summary_test
`default_nettype wire
